// ==== logic/icwlf_pkg.sv ====
// package of constants for the interrupt controller with supply monitor flag
//
// Notes on behaviour
// - two-bit pin edge code: off/rise/fall/both
// - primary reg 0: global, pins, touch
// - primary reg 1: serial, groups 0/1, converter
// - primary reg 2: group 2, timebases, group 3
// - group reg 0: compact timer 0 bits
// - group reg 1: compact timer 1, standard timer
// - group reg 2: periodic timer, serial module
// - edge register upper nibble zero, resets off
// - every source has enable and flag
// - supply low flag follows comparator output while monitor runs
// - three-bit threshold drives comparator select
// - monitor on bit and bandgap buffer bit
// - monitor held off during sleep
// - monitor flag set after debounce delay
// - new monitor flag wakes from idle
// - group reg 3: monitor and eeprom bits
// - flags latch regardless; vector needs both enables
// - service clears global enable, flags keep latching
// - newly set flag makes wake event in sleep or idle
package icwlf_pkg;

  // ----------------------------------------
  // register indices on the plain port
  // ----------------------------------------
  localparam logic [3:0] ADDR_EDGE_SEL = 4'h0;
  localparam logic [3:0] ADDR_PRIM0 = 4'h1;
  localparam logic [3:0] ADDR_PRIM1 = 4'h2;
  localparam logic [3:0] ADDR_PRIM2 = 4'h3;
  localparam logic [3:0] ADDR_GRP0 = 4'h4;
  localparam logic [3:0] ADDR_GRP1 = 4'h5;
  localparam logic [3:0] ADDR_GRP2 = 4'h6;
  localparam logic [3:0] ADDR_GRP3 = 4'h7;
  localparam logic [3:0] ADDR_MONITOR = 4'h8;

  // ----------------------------------------
  // reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int MON_LOW_BIT = 5;
  localparam int MON_ON_BIT = 4;
  localparam int MON_BG_BIT = 3;
  localparam int GIE_BIT = 0;

  // edge selector codes
  localparam logic [1:0] EDGE_OFF = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_FALL = 2'b10;
  localparam logic [1:0] EDGE_BOTH = 2'b11;

  // primary sources, index is also vector and priority (0 highest)
  localparam int NUM_PRIM = 11;
  // member sources of the four groups
  localparam int NUM_SUB = 11;
  localparam logic [10:0] GRP0_MASK = 11'h003;
  localparam logic [10:0] GRP1_MASK = 11'h03c;
  localparam logic [10:0] GRP2_MASK = 11'h1c0;
  localparam logic [10:0] GRP3_MASK = 11'h600;

  // ----------------------------------------
  // supply monitor debounce timing
  // ----------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int MON_DEBOUNCE_US = 15;
  localparam int MON_DEBOUNCE_CYC = MON_DEBOUNCE_US * CLK_MHZ;
  localparam logic [10:0] MON_DEBOUNCE_LAST = 11'(MON_DEBOUNCE_CYC - 1);

endpackage

// ==== logic/icwlf_pin_edge.sv ====
// synchroniser and edge selector for one external interrupt pin
`timescale 1ns/1ps
`default_nettype none
module icwlf_pin_edge
  import icwlf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic pin_raw,
  input wire logic [1:0] edge_sel,
  output logic edge_pulse
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] sync; // two-stage synchroniser
    logic last; // previous synchronised level
  } icwlf_edge_state_t;

  icwlf_edge_state_t s_q;
  icwlf_edge_state_t s_d;
  logic rise;
  logic fall;

  // next state and edge decode
  always_comb
  begin
    s_d = s_q;
    s_d.sync = {s_q.sync[0], pin_raw};
    s_d.last = s_q.sync[1];
    // only the second stage is looked at
    rise = s_q.sync[1] & ~s_q.last;
    fall = ~s_q.sync[1] & s_q.last;
    case (edge_sel)
      EDGE_OFF: edge_pulse = 1'b0;
      EDGE_RISE: edge_pulse = rise;
      EDGE_FALL: edge_pulse = fall;
      EDGE_BOTH: edge_pulse = rise | fall;
      default: edge_pulse = 1'b0;
    endcase
  end

  // register the state
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

endmodule
`default_nettype wire

// ==== logic/icwlf_top.sv ====
// interrupt request and enable bank with supply monitor control
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module icwlf_top
  import icwlf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // external pins, asynchronous
  input wire logic [1:0] ext_pin_raw,
  // one-cycle event pulses from peripherals
  input wire logic touch_evt,
  input wire logic serial_port_evt,
  input wire logic converter_evt,
  input wire logic [1:0] timebase_evt,
  input wire logic [1:0] ctm_period_evt,
  input wire logic [1:0] ctm_amatch_evt,
  input wire logic stm_period_evt,
  input wire logic stm_amatch_evt,
  input wire logic ptm_period_evt,
  input wire logic ptm_amatch_evt,
  input wire logic serial_module_evt,
  input wire logic eeprom_evt,
  // supply comparator output, asynchronous
  input wire logic supply_low_raw,
  // power modes from the clock controller
  input wire logic sleep_mode,
  input wire logic idle_mode,
  // cpu sequencer
  input wire logic irq_ack,
  output logic irq_req,
  output logic [3:0] irq_vector,
  output logic wake_evt,
  // comparator controls
  output logic supply_monitor_on,
  output logic bandgap_buffer_on,
  output logic [2:0] supply_threshold_sel
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] edge_sel; // pin1 in [3:2], pin0 in [1:0]
    logic global_irq_enable; // global gate
    logic [10:0] pen; // primary enables
    logic [10:0] pfl; // primary flags
    logic [10:0] sen; // group member enables
    logic [10:0] sfl; // group member flags
    logic [3:0] grp_prev; // last group request level
    logic mon_en; // software monitor on bit
    logic mon_act; // monitor really running
    logic bg_on; // bandgap buffer bit
    logic [2:0] thr; // threshold code
    logic [1:0] low_sync; // comparator synchroniser
    logic [10:0] deb_cnt; // debounce counter
    logic deb_done; // flag already raised this episode
    logic [7:0] rdata; // read data register
    logic req; // vector request
    logic [3:0] vec; // chosen vector
    logic wake; // wake pulse
  } icwlf_state_t;

  icwlf_state_t s_q;
  icwlf_state_t s_d;

  // ----------------------------------------
  // combinational helpers
  // ----------------------------------------
  logic [1:0] pin_evt; // decoded pin edges
  logic supply_low; // synchronised and gated low flag
  logic mon_set; // debounced monitor event
  logic [10:0] sub_set; // member set events
  logic [10:0] prim_set; // primary set events
  logic [10:0] sfl_w; // member flags after write
  logic [10:0] pfl_w; // primary flags after write
  logic [10:0] ack_clr; // flag cleared by service
  logic [3:0] grp_now; // group request levels
  logic [3:0] grp_rise; // newly raised group requests
  logic [10:0] pend; // enabled pending requests
  logic ack_ok; // acknowledge of a live request
  logic [7:0] rd_mux; // read value

  // ----------------------------------------
  // pin edge detectors
  // ----------------------------------------
  icwlf_pin_edge u_pin0 (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_raw(ext_pin_raw[0]),
    .edge_sel(s_q.edge_sel[1:0]),
    .edge_pulse(pin_evt[0])
  );

  icwlf_pin_edge u_pin1 (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_raw(ext_pin_raw[1]),
    .edge_sel(s_q.edge_sel[3:2]),
    .edge_pulse(pin_evt[1])
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    mon_set = 1'b0;

    // supply monitor: comparator sync and sleep gating
    s_d.low_sync = {s_q.low_sync[0], supply_low_raw};
    supply_low = s_q.low_sync[1] & s_q.mon_act;

    // debounce: the flag only fires after a steady low stretch
    if (!supply_low)
    begin
      s_d.deb_cnt = '0;
      s_d.deb_done = 1'b0;
    end
    else if (!s_q.deb_done)
    begin
      if (s_q.deb_cnt == MON_DEBOUNCE_LAST)
      begin
        s_d.deb_done = 1'b1;
        mon_set = 1'b1;
      end
      else
        s_d.deb_cnt = s_q.deb_cnt + 11'h001;
    end

    // member events, index order of the member masks
    sub_set = {eeprom_evt, mon_set, serial_module_evt,
               ptm_amatch_evt, ptm_period_evt,
               stm_amatch_evt, stm_period_evt,
               ctm_amatch_evt[1], ctm_period_evt[1],
               ctm_amatch_evt[0], ctm_period_evt[0]};

    // group request level from enabled members
    grp_now[0] = |(s_q.sfl & s_q.sen & GRP0_MASK);
    grp_now[1] = |(s_q.sfl & s_q.sen & GRP1_MASK);
    grp_now[2] = |(s_q.sfl & s_q.sen & GRP2_MASK);
    grp_now[3] = |(s_q.sfl & s_q.sen & GRP3_MASK);
    // edge only, so a serviced group flag is not raised again
    // while the same member stays pending
    grp_rise = grp_now & ~s_q.grp_prev;
    s_d.grp_prev = grp_now;

    // primary events, index is the vector number
    prim_set = {grp_rise[3], timebase_evt[1], timebase_evt[0],
                grp_rise[2], converter_evt, grp_rise[1],
                grp_rise[0], serial_port_evt, touch_evt,
                pin_evt[1], pin_evt[0]};

    // service of the current vector
    ack_ok = irq_ack & s_q.req;
    ack_clr = '0;
    if (ack_ok)
      ack_clr[s_q.vec] = 1'b1;

    // software writes to flags and enables
    sfl_w = s_q.sfl;
    pfl_w = s_q.pfl;
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_EDGE_SEL:
          s_d.edge_sel = reg_wdata[3:0];
        ADDR_PRIM0:
        begin
          s_d.global_irq_enable = reg_wdata[GIE_BIT];
          s_d.pen[2:0] = reg_wdata[3:1];
          pfl_w[2:0] = reg_wdata[6:4];
        end
        ADDR_PRIM1:
        begin
          s_d.pen[6:3] = reg_wdata[3:0];
          pfl_w[6:3] = reg_wdata[7:4];
        end
        ADDR_PRIM2:
        begin
          s_d.pen[10:7] = reg_wdata[3:0];
          pfl_w[10:7] = reg_wdata[7:4];
        end
        ADDR_GRP0:
        begin
          s_d.sen[1:0] = reg_wdata[1:0];
          sfl_w[1:0] = reg_wdata[5:4];
        end
        ADDR_GRP1:
        begin
          s_d.sen[5:2] = reg_wdata[3:0];
          sfl_w[5:2] = reg_wdata[7:4];
        end
        ADDR_GRP2:
        begin
          s_d.sen[8:6] = reg_wdata[2:0];
          sfl_w[8:6] = reg_wdata[6:4];
        end
        ADDR_GRP3:
        begin
          s_d.sen[10:9] = reg_wdata[1:0];
          sfl_w[10:9] = reg_wdata[5:4];
        end
        ADDR_MONITOR:
        begin
          s_d.mon_en = reg_wdata[MON_ON_BIT];
          s_d.bg_on = reg_wdata[MON_BG_BIT];
          s_d.thr = reg_wdata[2:0];
        end
        default:
          s_d.thr = s_q.thr; // unmapped: ignored
      endcase
    end

    // set beats software clear and service clear
    s_d.sfl = sfl_w | sub_set;
    s_d.pfl = (pfl_w & ~ack_clr) | prim_set;

    // service blocks nesting until software sets it again
    if (ack_ok)
      s_d.global_irq_enable = 1'b0;

    // detector runs only when enabled and not asleep
    s_d.mon_act = s_d.mon_en & ~sleep_mode;

    // wake in sleep or idle on a flag that goes from clear to set
    s_d.wake = (sleep_mode | idle_mode) &
               (|((prim_set & ~s_q.pfl) | (sub_set & ~s_q.sfl)));

    // request and vector from the next state, so they drop
    // together with the global enable after service
    pend = s_d.pfl & s_d.pen;
    s_d.req = s_d.global_irq_enable & (|pend);
    s_d.vec = 4'h0;
    for (int i = NUM_PRIM - 1; i >= 0; i--)
    begin
      if (pend[i])
        s_d.vec = 4'(i);
    end

    // read decode, data appears in the following cycle
    case (reg_addr)
      ADDR_EDGE_SEL:
        rd_mux = {4'h0, s_q.edge_sel};
      ADDR_PRIM0:
        rd_mux = {1'b0, s_q.pfl[2:0], s_q.pen[2:0],
                  s_q.global_irq_enable};
      ADDR_PRIM1:
        rd_mux = {s_q.pfl[6:3], s_q.pen[6:3]};
      ADDR_PRIM2:
        rd_mux = {s_q.pfl[10:7], s_q.pen[10:7]};
      ADDR_GRP0:
        rd_mux = {2'b00, s_q.sfl[1:0], 2'b00, s_q.sen[1:0]};
      ADDR_GRP1:
        rd_mux = {s_q.sfl[5:2], s_q.sen[5:2]};
      ADDR_GRP2:
        rd_mux = {1'b0, s_q.sfl[8:6], 1'b0, s_q.sen[8:6]};
      ADDR_GRP3:
        rd_mux = {2'b00, s_q.sfl[10:9], 2'b00, s_q.sen[10:9]};
      ADDR_MONITOR:
        rd_mux = {2'b00, supply_low, s_q.mon_en, s_q.bg_on,
                  s_q.thr};
      default:
        rd_mux = 8'h00; // unmapped reads as zero
    endcase
    s_d.rdata = reg_rd ? rd_mux : 8'h00;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // everything clears on reset: pins off, all gated
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.rdata <= RST_BYTE;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = s_q.rdata;
  assign irq_req = s_q.req;
  assign irq_vector = s_q.vec;
  assign wake_evt = s_q.wake;
  assign supply_monitor_on = s_q.mon_act;
  assign bandgap_buffer_on = s_q.bg_on;
  assign supply_threshold_sel = s_q.thr;

endmodule
`default_nettype wire

// ==== tb/icwlf_checker.sv ====
// port-level assertion checker for the interrupt bank
`timescale 1ns/1ps
`default_nettype none
module icwlf_checker
  import icwlf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic irq_ack,
  input wire logic irq_req,
  input wire logic [3:0] irq_vector,
  input wire logic wake_evt,
  input wire logic supply_monitor_on,
  input wire logic bandgap_buffer_on,
  input wire logic [2:0] supply_threshold_sel
);
  // ----------------------------------------
  // one clock domain, reset masks everything
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  AST_UNMAPPED: assert property ($past(reg_rd && reg_addr > 4'h8) |-> reg_rdata == 8'h00)
    else $error("unmapped index read not zero");
  AST_THR_BG: assert property ((reg_wr && reg_addr == ADDR_MONITOR) |=>
    (supply_threshold_sel == $past(reg_wdata[2:0]) && bandgap_buffer_on == $past(reg_wdata[3])))
    else $error("threshold or bandgap not taken from write");
  AST_MON_OFF: assert property ((reg_wr && reg_addr == ADDR_MONITOR && !reg_wdata[4]) |-> ##2 !supply_monitor_on)
    else $error("monitor stays on after switch off");
  AST_SLEEP: assert property (($past(sleep_mode, 2) && $past(sleep_mode)) |-> !supply_monitor_on)
    else $error("monitor on during sleep");
  AST_ACK: assert property ((irq_req && irq_ack) |=> !irq_req)
    else $error("request survives service");
  AST_HOLD: assert property ((irq_req && !irq_ack && !reg_wr) |=> irq_req)
    else $error("request dropped without cause");
  AST_VEC: assert property (irq_req |-> irq_vector <= 4'ha)
    else $error("vector out of range");
  AST_WAKE: assert property (wake_evt |-> (sleep_mode || idle_mode || $past(sleep_mode || idle_mode)))
    else $error("wake outside low power modes");
  // main scenarios seen
  COV_SERVICE: cover property (irq_req && irq_ack);
  COV_WAKE: cover property (wake_evt);
  COV_MON: cover property (supply_monitor_on);
endmodule
bind icwlf_top icwlf_checker i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sleep_mode(sleep_mode), .idle_mode(idle_mode), .irq_ack(irq_ack), .irq_req(irq_req),
  .irq_vector(irq_vector), .wake_evt(wake_evt), .supply_monitor_on(supply_monitor_on),
  .bandgap_buffer_on(bandgap_buffer_on), .supply_threshold_sel(supply_threshold_sel));
`default_nettype wire

// ==== tb/icwlf_cpu_model.sv ====
// cpu sequencer model: services a request after a chosen wait
`timescale 1ns/1ps
`default_nettype none
module icwlf_cpu_model
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic irq_req,
  input wire logic [1:0] ack_wait,
  output logic irq_ack
);
  logic [1:0] wait_q; // cycles the request has stood
  // ack is a single pulse, only raised while a request stands
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !irq_req || irq_ack)
    begin
      wait_q <= 2'h0;
      irq_ack <= 1'b0;
    end
    else if (wait_q == ack_wait)
      irq_ack <= 1'b1;
    else
      wait_q <= wait_q + 2'h1;
  end
endmodule
`default_nettype wire

// ==== tb/icwlf_top_tb.sv ====
// self-checking bench for the interrupt bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
  begin comparisons++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected %s expected %0h seen %0h", what, exp, got); end end
module icwlf_top_tb;
  import icwlf_pkg::*;
  logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq_ack, irq_req;
  logic [3:0] reg_addr = 4'h0, irq_vector;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [1:0] ext_pin_raw = 2'h0, ack_wait = 2'h0;
  logic [14:0] ev = 15'h0; // event pulses, one bit a source
  logic supply_low_raw = 1'b0, sleep_mode = 1'b0, idle_mode = 1'b0, wake_evt;
  logic supply_monitor_on, bandgap_buffer_on;
  logic [2:0] supply_threshold_sel;
  int fails = 0, comparisons = 0, wakes = 0, i, p, c;
  // vector per event bit; group members share one
  logic [3:0] vec_tab [15] = '{4'h2, 4'h3, 4'h6, 4'h8, 4'h9, 4'h4, 4'h4, 4'h5, 4'h5, 4'h5,
    4'h5, 4'h7, 4'h7, 4'h7, 4'ha};
  logic [7:0] mask_tab [10] = '{8'h0f, 8'h7e, 8'hff, 8'hff, 8'h33, 8'hff, 8'h77, 8'h33,
    8'h1f, 8'h00};
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (wake_evt === 1'b1) wakes++;
  icwlf_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_pin_raw(ext_pin_raw), .touch_evt(ev[0]), .serial_port_evt(ev[1]),
    .converter_evt(ev[2]), .timebase_evt(ev[4:3]), .ctm_period_evt({ev[7], ev[5]}),
    .ctm_amatch_evt({ev[8], ev[6]}), .stm_period_evt(ev[9]), .stm_amatch_evt(ev[10]),
    .ptm_period_evt(ev[11]), .ptm_amatch_evt(ev[12]), .serial_module_evt(ev[13]),
    .eeprom_evt(ev[14]), .supply_low_raw(supply_low_raw), .sleep_mode(sleep_mode),
    .idle_mode(idle_mode), .irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector),
    .wake_evt(wake_evt), .supply_monitor_on(supply_monitor_on),
    .bandgap_buffer_on(bandgap_buffer_on), .supply_threshold_sel(supply_threshold_sel));
  icwlf_cpu_model i_cpu (.sys_clk(sys_clk), .sys_rst(sys_rst), .irq_req(irq_req),
    .ack_wait(ack_wait), .irq_ack(irq_ack));
  // ----------------------------------------
  // register port tasks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // answer stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("register", exp, reg_rdata)
  endtask
  task automatic idle_for(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // enables everywhere, all flags cleared, groups before primaries
  task automatic en_all;
    wr(ADDR_GRP3, 8'h03);
    wr(ADDR_GRP2, 8'h07);
    wr(ADDR_GRP1, 8'h0f);
    wr(ADDR_GRP0, 8'h03);
    wr(ADDR_PRIM2, 8'h0f);
    wr(ADDR_PRIM1, 8'h0f);
    wr(ADDR_PRIM0, 8'h0f);
  endtask
  task automatic pulse(input logic [14:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= 15'h0;
  endtask
  // bounded wait for the cpu ack, then check vector and drop
  task automatic service(input logic [3:0] v);
    int n;
    n = 0;
    while (irq_ack !== 1'b1 && n < 40)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    `CHK("vector", v, irq_vector)
    idle_for(1);
    `CHK("request after service", 1'b0, irq_req)
  endtask
  task automatic give_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    idle_for(10);
    sys_rst <= 1'b0;
    for (i = 0; i < 10; i++) rd(4'(i), 8'h00);
    // global left off so no service disturbs readback
    for (i = 0; i < 10; i++) wr(4'(i), (i == 1) ? 8'hfe : 8'hff);
    for (i = 0; i < 10; i++) rd(4'(i), mask_tab[i]);
    `CHK("threshold", 3'h7, supply_threshold_sel)
    `CHK("bandgap", 1'b1, bandgap_buffer_on)
    `CHK("monitor on", 1'b1, supply_monitor_on)
    for (i = 9; i >= 0; i--) wr(4'(i), 8'h00);
    en_all();
    // each source in turn, cpu answering fast and slow
    for (i = 0; i < 15; i++)
    begin
      ack_wait <= 2'(i * 3);
      pulse(15'h1 << i);
      service(vec_tab[i]);
      en_all();
    end
    // edge codes, pins enabled, global off
    for (p = 0; p < 2; p++)
      for (c = 0; c < 4; c++)
      begin
        wr(ADDR_PRIM0, 8'h06);
        wr(ADDR_EDGE_SEL, 8'(c << (2 * p)));
        ext_pin_raw[p] <= 1'b1;
        idle_for(6);
        rd(ADDR_PRIM0, 8'h06 | (8'(c[0]) << (4 + p)));
        wr(ADDR_PRIM0, 8'h06);
        ext_pin_raw[p] <= 1'b0;
        idle_for(6);
        rd(ADDR_PRIM0, 8'h06 | (8'(c[1]) << (4 + p)));
      end
    // both pins at once: priority, second flag kept through service
    en_all();
    wr(ADDR_EDGE_SEL, 8'h0f);
    ext_pin_raw <= 2'b11;
    service(4'h0);
    wr(ADDR_PRIM0, 8'h2f);
    service(4'h1);
    // flag latches without global, member without enable stays out
    en_all();
    wr(ADDR_PRIM0, 8'h00);
    wr(ADDR_GRP0, 8'h00);
    pulse(15'h0024);
    idle_for(3);
    `CHK("request without global", 1'b0, irq_req)
    rd(ADDR_PRIM1, 8'h8f);
    rd(ADDR_GRP0, 8'h10);
    wr(ADDR_PRIM0, 8'h01);
    service(4'h6);
    en_all();
    `CHK("wakes outside modes", 0, wakes)
    // supply monitor in idle: debounce then flag and wake
    idle_mode <= 1'b1;
    wr(ADDR_MONITOR, 8'h10);
    supply_low_raw <= 1'b1;
    idle_for(4);
    rd(ADDR_MONITOR, 8'h30);
    idle_for(1790);
    rd(ADDR_GRP3, 8'h03);
    idle_for(100);
    rd(ADDR_GRP3, 8'h13);
    `CHK("wake seen", 1'b1, wakes > 0)
    sleep_mode <= 1'b1;
    idle_for(4);
    `CHK("monitor on in sleep", 1'b0, supply_monitor_on)
    rd(ADDR_MONITOR, 8'h10);
    give_verdict();
  end
  // hang guard, well beyond the few thousand cycles needed
  initial
  begin
    #160000;
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
